// ---- sfp_host.sv ----
// Host controller driving a sector-programmed parallel flash over its pins
`timescale 1ns/1ps
module sfp_host #(
    parameter int BLC_CYCLES = sfp_pkg::BLC_CYC,
    parameter int WC_CYCLES  = sfp_pkg::WC_CYC
) (
    // Clock and reset
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // Request side
    input  wire logic                          req_valid,
    input  wire sfp_pkg::sfp_req_t             req,
    output logic                               req_ready,
    // Answer side
    output logic                               rsp_valid,
    output sfp_pkg::sfp_rsp_t                  rsp,
    // Status
    output logic                               load_open,
    output logic                               sector_full,
    output logic                               prog_busy,
    output logic [sfp_pkg::LCNT_W-1:0]         load_count,
    // Flash pins
    output logic [sfp_pkg::ADDR_W-1:0]         flash_addr,
    output logic                               flash_ce_n,
    output logic                               flash_oe_n,
    output logic                               flash_we_n,
    output logic [sfp_pkg::DATA_W-1:0]         flash_dq_out,
    output logic                               flash_dq_oe,
    input  wire logic [sfp_pkg::DATA_W-1:0]    flash_dq_in
);

    // ****************************************************
    // Data pin synchroniser
    // ****************************************************
    logic [sfp_pkg::DATA_W-1:0] dq_s1_ff, dq_s2_ff, dq_s3_ff, dq_q_ff, nxt_dq_q;

    always_comb begin
        nxt_dq_q = (dq_s3_ff & ~(dq_s2_ff ^ dq_s3_ff)) | (dq_q_ff & (dq_s2_ff ^ dq_s3_ff));
    end

    always_ff @(posedge mclk) begin
        dq_s1_ff <= flash_dq_in;
        dq_s2_ff <= dq_s1_ff;
        dq_s3_ff <= dq_s2_ff;
        dq_q_ff  <= sys_rst ? '0 : nxt_dq_q;
    end

    // ****************************************************
    // Sequencer and load tracking
    // ****************************************************
    localparam logic [sfp_pkg::TMR_W-1:0] BLC_LAST = sfp_pkg::TMR_W'(BLC_CYCLES - 1);
    localparam logic [sfp_pkg::TMR_W-1:0] WC_LAST  = sfp_pkg::TMR_W'(WC_CYCLES - 1);
    localparam logic [sfp_pkg::CNT_W-1:0] WP_LAST  = sfp_pkg::CNT_W'(sfp_pkg::WP_CYC - 1);
    localparam logic [sfp_pkg::CNT_W-1:0] WPH_LAST = sfp_pkg::CNT_W'(sfp_pkg::WPH_CYC - 1);
    localparam logic [sfp_pkg::CNT_W-1:0] RD_LAST  =
        sfp_pkg::CNT_W'(sfp_pkg::ACC_CYC + sfp_pkg::SYNC_CYC);
    localparam logic [sfp_pkg::CNT_W-1:0] GAP_LAST = sfp_pkg::CNT_W'(sfp_pkg::OEHP_CYC - 1);
    localparam logic [sfp_pkg::LCNT_W-1:0] FULL_CNT = sfp_pkg::LCNT_W'(sfp_pkg::SEC_BYTES);

    sfp_pkg::sfp_state_t                state_ff, nxt_state;
    sfp_pkg::sfp_op_t                   op_ff, nxt_op;
    logic [sfp_pkg::CNT_W-1:0]          cnt_ff, nxt_cnt;
    logic [sfp_pkg::TMR_W-1:0]          gap_ff, nxt_gap, wc_ff, nxt_wc, poll_tmr_ff, nxt_poll_tmr;
    logic [sfp_pkg::SEC_W-1:0]          sector_ff, nxt_sector, sec_sel;
    logic                               poll_first_ff, nxt_poll_first;
    logic                               poll_prev_ff, nxt_poll_prev;
    logic                               poll_done_ff, nxt_poll_done;
    logic                               gap_expire;
    logic                               req_ready_ff, nxt_req_ready;
    logic                               rsp_valid_ff, nxt_rsp_valid;
    sfp_pkg::sfp_rsp_t                  rsp_ff, nxt_rsp;
    logic                               load_open_ff, nxt_load_open;
    logic                               prog_busy_ff, nxt_prog_busy;
    logic [sfp_pkg::LCNT_W-1:0]         load_cnt_ff, nxt_load_cnt;
    logic                               sector_full_ff, nxt_sector_full;
    logic [sfp_pkg::ADDR_W-1:0]         addr_ff, nxt_addr;
    logic                               ce_n_ff, nxt_ce_n, oe_n_ff, nxt_oe_n, we_n_ff, nxt_we_n;
    logic [sfp_pkg::DATA_W-1:0]         dq_out_ff, nxt_dq_out;
    logic                               dq_oe_ff, nxt_dq_oe;

    always_comb begin
        nxt_state      = state_ff;
        nxt_op         = op_ff;
        nxt_cnt        = cnt_ff;
        nxt_gap        = gap_ff;
        nxt_wc         = wc_ff;
        nxt_poll_tmr   = poll_tmr_ff;
        nxt_sector     = sector_ff;
        nxt_poll_first = poll_first_ff;
        nxt_poll_prev  = poll_prev_ff;
        nxt_poll_done  = poll_done_ff;
        nxt_req_ready  = req_ready_ff;
        nxt_rsp_valid  = 1'b0;
        nxt_rsp        = rsp_ff;
        nxt_load_open  = load_open_ff;
        nxt_prog_busy  = prog_busy_ff;
        nxt_load_cnt   = load_cnt_ff;
        nxt_addr       = addr_ff;
        nxt_ce_n       = ce_n_ff;
        nxt_oe_n       = oe_n_ff;
        nxt_we_n       = we_n_ff;
        nxt_dq_out     = dq_out_ff;
        nxt_dq_oe      = dq_oe_ff;
        // Window closes: device now erases and programs the sector
        gap_expire     = load_open_ff && (gap_ff == BLC_LAST) && (state_ff == sfp_pkg::ST_IDLE);
        sec_sel        = load_open_ff ? sector_ff : req.addr[sfp_pkg::ADDR_W-1:sfp_pkg::SEC_LSB];
        if (load_open_ff && state_ff == sfp_pkg::ST_IDLE) begin
            nxt_gap = gap_ff + 1'b1;
        end
        if (gap_expire) begin
            nxt_load_open = 1'b0;
            nxt_prog_busy = 1'b1;
            nxt_wc        = '0;
        end
        if (prog_busy_ff) begin
            nxt_wc = wc_ff + 1'b1;
            if (wc_ff == WC_LAST) begin
                nxt_prog_busy = 1'b0;
            end
        end
        unique case (state_ff)
            sfp_pkg::ST_IDLE: begin
                if (req_valid) begin
                    nxt_op        = req.op;
                    nxt_cnt       = '0;
                    nxt_req_ready = 1'b0;
                    nxt_rsp       = '0;
                    unique case (req.op)
                        sfp_pkg::OP_READ, sfp_pkg::OP_ID, sfp_pkg::OP_POLL: begin
                            if (req.op == sfp_pkg::OP_READ) begin
                                nxt_addr = req.addr;
                            end else if (req.op == sfp_pkg::OP_ID) begin
                                nxt_addr = {{(sfp_pkg::ADDR_W-1){1'b0}}, req.addr[0]};
                            end
                            nxt_poll_first = 1'b1;
                            nxt_poll_done  = 1'b0;
                            nxt_poll_tmr   = '0;
                            nxt_ce_n       = 1'b0;
                            nxt_oe_n       = 1'b0;
                            nxt_state      = sfp_pkg::ST_RD;
                        end
                        sfp_pkg::OP_CMD: begin
                            nxt_addr  = {{(sfp_pkg::ADDR_W-sfp_pkg::CMD_ADDR_W){1'b0}},
                                         req.addr[sfp_pkg::CMD_ADDR_W-1:0]};
                            nxt_dq_out = req.data;
                            nxt_dq_oe  = 1'b1;
                            nxt_oe_n   = 1'b1;
                            nxt_ce_n   = 1'b0;
                            nxt_we_n   = 1'b0;
                            nxt_state  = sfp_pkg::ST_WR_LOW;
                        end
                        sfp_pkg::OP_LOAD: begin
                            if (prog_busy_ff || gap_expire) begin
                                nxt_rsp.err   = 1'b1;
                                nxt_rsp_valid = 1'b1;
                                nxt_req_ready = 1'b1;
                            end else begin
                                nxt_sector = sec_sel;
                                nxt_addr   = {sec_sel, req.addr[sfp_pkg::SEC_LSB-1:0]};
                                if (!load_open_ff) begin
                                    nxt_load_cnt = '0;
                                end
                                nxt_load_open = 1'b1;
                                nxt_gap    = '0;
                                nxt_dq_out = req.data;
                                nxt_dq_oe  = 1'b1;
                                nxt_oe_n   = 1'b1;
                                nxt_ce_n   = 1'b0;
                                nxt_we_n   = 1'b0;
                                nxt_state  = sfp_pkg::ST_WR_LOW;
                            end
                        end
                        default: begin
                            nxt_rsp.err   = 1'b1;
                            nxt_rsp_valid = 1'b1;
                            nxt_req_ready = 1'b1;
                        end
                    endcase
                end
            end
            sfp_pkg::ST_WR_LOW: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == WP_LAST) begin
                    nxt_we_n  = 1'b1;
                    nxt_ce_n  = 1'b1;
                    nxt_cnt   = '0;
                    nxt_state = sfp_pkg::ST_WR_HIGH;
                    if (op_ff == sfp_pkg::OP_LOAD) begin
                        nxt_load_cnt = load_cnt_ff + 1'b1;
                    end
                end
            end
            sfp_pkg::ST_WR_HIGH: begin
                nxt_cnt = cnt_ff + 1'b1;
                if (cnt_ff == WPH_LAST) begin
                    nxt_dq_oe     = 1'b0;
                    nxt_state     = sfp_pkg::ST_IDLE;
                    nxt_req_ready = 1'b1;
                    nxt_rsp_valid = 1'b1;
                end
            end
            sfp_pkg::ST_RD: begin
                nxt_cnt      = cnt_ff + 1'b1;
                nxt_poll_tmr = poll_tmr_ff + 1'b1;
                if (cnt_ff == RD_LAST) begin
                    nxt_ce_n      = 1'b1;
                    nxt_oe_n      = 1'b1;
                    nxt_cnt       = '0;
                    nxt_rsp.data  = dq_q_ff;
                    nxt_state     = sfp_pkg::ST_RD_GAP;
                    nxt_poll_prev = dq_q_ff[sfp_pkg::TOGGLE_BIT];
                    nxt_poll_first = 1'b0;
                    if (op_ff != sfp_pkg::OP_POLL || (!poll_first_ff &&
                        dq_q_ff[sfp_pkg::TOGGLE_BIT] == poll_prev_ff)) begin
                        nxt_poll_done = 1'b1;
                    end
                end
            end
            sfp_pkg::ST_RD_GAP: begin
                nxt_cnt      = cnt_ff + 1'b1;
                nxt_poll_tmr = poll_tmr_ff + 1'b1;
                if (cnt_ff == GAP_LAST) begin
                    nxt_cnt = '0;
                    if (poll_done_ff || poll_tmr_ff >= WC_LAST) begin
                        nxt_rsp.timeout = !poll_done_ff;
                        nxt_state       = sfp_pkg::ST_IDLE;
                        nxt_req_ready   = 1'b1;
                        nxt_rsp_valid   = 1'b1;
                        if (op_ff == sfp_pkg::OP_POLL && poll_done_ff) begin
                            nxt_prog_busy = 1'b0;
                        end
                    end else begin
                        nxt_ce_n  = 1'b0;
                        nxt_oe_n  = 1'b0;
                        nxt_state = sfp_pkg::ST_RD;
                    end
                end
            end
            default: begin
                nxt_state = sfp_pkg::ST_IDLE;
            end
        endcase
        nxt_sector_full = (nxt_load_cnt == FULL_CNT);
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_ff      <= sfp_pkg::ST_IDLE;
            op_ff         <= sfp_pkg::OP_READ;
            cnt_ff        <= '0;
            gap_ff        <= '0;
            wc_ff         <= '0;
            poll_tmr_ff   <= '0;
            sector_ff     <= '0;
            poll_first_ff <= 1'b1;
            poll_prev_ff  <= 1'b0;
            poll_done_ff  <= 1'b0;
            req_ready_ff  <= 1'b1;
            rsp_valid_ff  <= 1'b0;
            rsp_ff        <= '0;
            load_open_ff  <= 1'b0;
            prog_busy_ff  <= 1'b0;
            load_cnt_ff   <= '0;
            sector_full_ff <= 1'b0;
            addr_ff       <= '0;
            ce_n_ff       <= 1'b1;
            oe_n_ff       <= 1'b1;
            we_n_ff       <= 1'b1;
            dq_out_ff     <= '0;
            dq_oe_ff      <= 1'b0;
        end else begin
            state_ff      <= nxt_state;
            op_ff         <= nxt_op;
            cnt_ff        <= nxt_cnt;
            gap_ff        <= nxt_gap;
            wc_ff         <= nxt_wc;
            poll_tmr_ff   <= nxt_poll_tmr;
            sector_ff     <= nxt_sector;
            poll_first_ff <= nxt_poll_first;
            poll_prev_ff  <= nxt_poll_prev;
            poll_done_ff  <= nxt_poll_done;
            req_ready_ff  <= nxt_req_ready;
            rsp_valid_ff  <= nxt_rsp_valid;
            rsp_ff        <= nxt_rsp;
            load_open_ff  <= nxt_load_open;
            prog_busy_ff  <= nxt_prog_busy;
            load_cnt_ff   <= nxt_load_cnt;
            sector_full_ff <= nxt_sector_full;
            addr_ff       <= nxt_addr;
            ce_n_ff       <= nxt_ce_n;
            oe_n_ff       <= nxt_oe_n;
            we_n_ff       <= nxt_we_n;
            dq_out_ff     <= nxt_dq_out;
            dq_oe_ff      <= nxt_dq_oe;
        end
    end

    assign req_ready    = req_ready_ff;
    assign rsp_valid    = rsp_valid_ff;
    assign rsp          = rsp_ff;
    assign load_open    = load_open_ff;
    assign prog_busy    = prog_busy_ff;
    assign load_count   = load_cnt_ff;
    assign sector_full  = sector_full_ff;
    assign flash_addr   = addr_ff;
    assign flash_ce_n   = ce_n_ff;
    assign flash_oe_n   = oe_n_ff;
    assign flash_we_n   = we_n_ff;
    assign flash_dq_out = dq_out_ff;
    assign flash_dq_oe  = dq_oe_ff;

    // ****************************************************
    // Checks
    // ****************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    chk_oe_write_high: assert property (!we_n_ff && !ce_n_ff |-> oe_n_ff)
        else $error("output enable low during a write strobe");
    chk_sector_same: assert property (
        $fell(we_n_ff) && op_ff == sfp_pkg::OP_LOAD |->
        addr_ff[sfp_pkg::ADDR_W-1:sfp_pkg::SEC_LSB] == sector_ff)
        else $error("load strobe with foreign sector address");
    chk_sector_held: assert property (
        $fell(we_n_ff) && op_ff == sfp_pkg::OP_LOAD |=>
        $stable(addr_ff[sfp_pkg::ADDR_W-1:sfp_pkg::SEC_LSB]) [*4])
        else $error("sector address moved during load strobe");
    chk_load_window: assert property (load_open_ff |-> gap_ff <= BLC_LAST)
        else $error("byte load window overrun");
    chk_full_count: assert property (load_cnt_ff <= FULL_CNT)
        else $error("more bytes loaded than a sector holds");
    chk_poll_addr: assert property (
        state_ff == sfp_pkg::ST_RD_GAP && nxt_state == sfp_pkg::ST_RD |=> $stable(addr_ff))
        else $error("polling address changed");
    chk_cmd_addr: assert property (
        $fell(we_n_ff) && op_ff == sfp_pkg::OP_CMD |->
        addr_ff[sfp_pkg::ADDR_W-1:sfp_pkg::CMD_ADDR_W] == '0 && dq_oe_ff)
        else $error("command write outside low address bits");
    chk_we_pulse: assert property (
        $fell(we_n_ff) |-> !we_n_ff [*5] ##1 we_n_ff)
        else $error("write pulse width wrong");
    chk_busy_refuse: assert property (
        state_ff == sfp_pkg::ST_IDLE && req_valid && req.op == sfp_pkg::OP_LOAD &&
        prog_busy_ff |=> rsp_valid_ff && rsp_ff.err && we_n_ff)
        else $error("load accepted during program cycle");

    cov_full_sector: cover property (load_cnt_ff == FULL_CNT && gap_expire);
    cov_poll_done: cover property (rsp_valid_ff && op_ff == sfp_pkg::OP_POLL && !rsp_ff.timeout);
    cov_cmd_write: cover property ($rose(we_n_ff) && op_ff == sfp_pkg::OP_CMD);

endmodule // sfp_host

// ---- sfp_pkg.sv ----
// Constants, types and carriers for the sector flash program host controller
// Notes on behaviour
// - Every byte load of a sector presents the same sector address on the sector address bits.
// - After a protection code sequence, the sector address is held on every following byte load.
// - Each byte load follows the previous one within the byte load window of 150 us.
// - A protection code sequence is followed by a load of the full 128-byte sector.
// - Toggle polling may use any address but keeps it unchanged for the whole poll.
// - Command sequences use the low fifteen address bits and eight data lines.
package sfp_pkg;

    // ****************************************************
    // Timing
    // ****************************************************
    localparam int CLK_NS    = 20;
    localparam int T_WP_NS   = 90;
    localparam int T_WPH_NS  = 100;
    localparam int T_ACC_NS  = 90;
    localparam int T_OEHP_NS = 150;
    localparam int WIN_US    = 150;
    localparam int PRG_MS    = 10;
    localparam int WP_CYC    = (T_WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC   = (T_WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC   = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
    localparam int OEHP_CYC  = (T_OEHP_NS + CLK_NS - 1) / CLK_NS;
    localparam int BLC_CYC   = (WIN_US * 1000) / CLK_NS;
    localparam int WC_CYC    = (PRG_MS * 1000000) / CLK_NS;
    localparam int SYNC_CYC  = 3;

    // ****************************************************
    // Widths and fields
    // ****************************************************
    localparam int ADDR_W     = 17;
    localparam int DATA_W     = 8;
    localparam int CMD_ADDR_W = 15;
    localparam int SEC_LSB    = 7;
    localparam int SEC_W      = ADDR_W - SEC_LSB;
    localparam int SEC_BYTES  = 128;
    localparam int TOGGLE_BIT = 6;
    localparam int CNT_W      = 4;
    localparam int LCNT_W     = 8;
    localparam int TMR_W      = 24;

    typedef enum logic [4:0] {
        OP_READ = 5'h01,
        OP_CMD  = 5'h02,
        OP_LOAD = 5'h04,
        OP_POLL = 5'h08,
        OP_ID   = 5'h10
    } sfp_op_t;

    typedef enum logic [4:0] {
        ST_IDLE    = 5'h01,
        ST_WR_LOW  = 5'h02,
        ST_WR_HIGH = 5'h04,
        ST_RD      = 5'h08,
        ST_RD_GAP  = 5'h10
    } sfp_state_t;

    typedef struct packed {
        sfp_op_t                 op;
        logic [ADDR_W-1:0]       addr;
        logic [DATA_W-1:0]       data;
    } sfp_req_t;

    typedef struct packed {
        logic                    err;
        logic                    timeout;
        logic [DATA_W-1:0]       data;
    } sfp_rsp_t;

endpackage

// ---- sfp_flash_model.sv ----
// Behavioural model of the sector flash device seen by the host controller
`timescale 1ns/1ps
module sfp_flash_model #(
    parameter int          BLC    = 40,
    parameter int          PROG   = 60,
    parameter logic [16:0] CMD_A  = 17'h01555,
    parameter logic [7:0]  ID_ON  = 8'h90,
    parameter logic [7:0]  ID_OFF = 8'hF0,
    parameter logic [7:0]  MAKER  = 8'hA5, // Arbitrary value
    parameter logic [7:0]  PART   = 8'h3C, // Arbitrary value
    parameter logic [7:0]  P_ON   = 8'h11, // Arbitrary command codes
    parameter logic [7:0]  P_OFF  = 8'h22,
    parameter logic [7:0]  LK_LO  = 8'h33,
    parameter logic [7:0]  LK_HI  = 8'h44,
    parameter int          BOOT   = 64     // Boot block size in sectors
) (
    // Host pins
    input  wire logic        mclk,
    input  wire logic [16:0] flash_addr,
    input  wire logic        flash_ce_n,
    input  wire logic        flash_oe_n,
    input  wire logic        flash_we_n,
    input  wire logic [7:0]  flash_dq_out,
    // Device data
    output logic [7:0]       flash_dq_in
);
    logic [7:0]   mem [int];
    logic [7:0]   buf_q [128];
    logic [127:0] got = '0;
    logic [9:0]   sec = '0;
    logic [7:0]   last = 8'h00;
    logic         busy = 1'h0, tgl = 1'h0, open_q = 1'h0, wr_q = 1'h0, rd_q = 1'h0;
    logic         id_mode = 1'h0;
    logic         prot = 1'h0, armed = 1'h0, p_nxt = 1'h0;
    logic [1:0]   lock = '0;
    int           idle = 0;
    int           prog = 0;
    wire wr = !flash_ce_n && !flash_we_n && flash_oe_n;
    wire rd = !flash_ce_n && !flash_oe_n && flash_we_n;

    always @(posedge mclk) begin
        wr_q <= wr;
        rd_q <= rd;
        if (rd) last <= flash_dq_in;
        if (rd_q && !rd && busy) tgl <= ~tgl;
        if (busy) prog = prog + 1;
        if (busy && prog >= PROG) begin
            busy <= 1'h0;
            if (armed) prot <= p_nxt;
            armed <= 1'h0;
        end
        if (wr && !wr_q) begin
            if (flash_addr == CMD_A && flash_dq_out inside {ID_ON, ID_OFF}) begin
                id_mode <= (flash_dq_out == ID_ON);
            end else if (flash_addr == CMD_A && flash_dq_out inside {P_ON, P_OFF}) begin
                armed <= 1'h1;
                p_nxt <= (flash_dq_out == P_ON);
            end else if (flash_addr == CMD_A && flash_dq_out inside {LK_LO, LK_HI}) begin
                lock[flash_dq_out == LK_HI] <= 1'h1;
            end else if (!busy && (!prot || armed) && !(lock[0] && flash_addr[16:7] < 10'(BOOT))
                         && !(lock[1] && flash_addr[16:7] >= 10'(1024 - BOOT))) begin
                if (!open_q) sec <= flash_addr[16:7];
                buf_q[flash_addr[6:0]] <= flash_dq_out;
                got[flash_addr[6:0]] <= 1'h1;
                open_q <= 1'h1;
                idle = 0;
            end
        end else if (open_q) begin
            idle = idle + 1;
            if (idle >= BLC) begin
                for (int i = 0; i < 128; i++) mem[{sec, i[6:0]}] = got[i] ? buf_q[i] : 8'h5A ^ i[7:0];
                got <= '0;
                open_q <= 1'h0;
                busy <= 1'h1;
                prog = 0;
            end
        end
    end

    always @* begin
        if (!rd) flash_dq_in = ~last;
        else if (busy) flash_dq_in = {1'h0, tgl, 6'h00};
        else if (id_mode && flash_addr[16:1] == '0) flash_dq_in = flash_addr[0] ? PART : MAKER;
        else flash_dq_in = mem.exists(int'(flash_addr)) ? mem[int'(flash_addr)] : 8'hFF;
    end
endmodule // sfp_flash_model

// ---- sector_flash_program_control_tb.sv ----
// Self-checking bench for the sector flash host controller
`timescale 1ns/1ps
module sector_flash_program_control_tb;
    typedef struct {
        sfp_pkg::sfp_op_t op;
        logic [16:0]      addr;
        logic [7:0]       data;
        logic [7:0]       exp;
    } sfp_row_t;
    logic mclk, sys_rst, req_valid, req_ready, rsp_valid, load_open, sector_full, prog_busy;
    logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
    logic [7:0] load_count, flash_dq_out, flash_dq_in;
    logic [16:0] flash_addr;
    sfp_pkg::sfp_req_t req;
    sfp_pkg::sfp_rsp_t rsp;
    int n_errors = 0, n_tests = 0, k;
    logic [16:0] raddr [5] = '{17'h00305, 17'h00400, 17'h003A0, 17'h00000, 17'h04000};
    logic [7:0]  rexp  [5] = '{8'h15, 8'hFF, 8'h30, 8'hFF, 8'h10};
    sfp_row_t rows [6] = '{
        '{sfp_pkg::OP_CMD, 17'h01555, 8'h90, 8'h00}, '{sfp_pkg::OP_ID, 17'h00000, 8'h00, 8'hA5},
        '{sfp_pkg::OP_ID, 17'h00001, 8'h00, 8'h3C}, '{sfp_pkg::OP_CMD, 17'h01555, 8'hF0, 8'h00},
        '{sfp_pkg::OP_READ, 17'h00000, 8'h00, 8'hFF}, '{sfp_pkg::OP_ID, 17'h00001, 8'h00, 8'hFF}};

    sfp_host #(.BLC_CYCLES(40), .WC_CYCLES(200)) sfp_host_inst (.mclk(mclk), .sys_rst(sys_rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp),
        .load_open(load_open), .sector_full(sector_full), .prog_busy(prog_busy),
        .load_count(load_count), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
        .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .flash_dq_out(flash_dq_out),
        .flash_dq_oe(flash_dq_oe), .flash_dq_in(flash_dq_in));
    sfp_flash_model sfp_flash_model_inst (.mclk(mclk), .flash_addr(flash_addr),
        .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
        .flash_dq_out(flash_dq_out), .flash_dq_in(flash_dq_in));

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t flag got %b expected %b", $time, got, exp);
        end
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t byte got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (n_errors == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Holds the request until taken, then waits for the answer pulse
    task automatic do_req(input sfp_pkg::sfp_op_t op, input logic [16:0] a, input logic [7:0] d);
        req <= '{op: op, addr: a, data: d};
        req_valid <= 1'h1;
        for (k = 0; k < 100 && req_ready !== 1'h1; k++) @(posedge mclk) #1;
        if (k >= 100) begin
            n_errors++;
            print_verdict();
        end
        @(posedge mclk) #1 req_valid <= 1'h0;
        for (k = 0; k < 6000 && rsp_valid !== 1'h1; k++) @(posedge mclk) #1;
        if (k >= 6000) begin
            n_errors++;
            print_verdict();
        end
        // One idle edge, so a one-cycle refusal never meets the next request
        @(posedge mclk) #1;
    endtask

    task automatic idle_chk();
        chk_bit(flash_ce_n & flash_oe_n & flash_we_n, 1'h1);
        chk_bit(req_ready, 1'h1);
        chk_bit(prog_busy | load_open | flash_dq_oe, 1'h0);
    endtask

    // Loads n bytes of one sector, then waits for and polls the program cycle
    task automatic burn(input logic [16:0] base, input int n);
        for (int j = 0; j < n; j++) begin
            do_req(sfp_pkg::OP_LOAD, base + 17'(j), 8'h10 + 8'(j));
        end
        for (k = 0; k < 200 && prog_busy !== 1'h1; k++) @(posedge mclk) #1;
        chk_bit(prog_busy, 1'h1);
        do_req(sfp_pkg::OP_POLL, base, 8'h00);
        chk_bit(rsp.timeout | prog_busy, 1'h0);
    endtask

    initial begin
        sys_rst = 1'h1;
        req_valid = 1'h0;
        req = '0;
        repeat (6) @(posedge mclk);
        #1 sys_rst = 1'h0;
        idle_chk();
        foreach (rows[i]) begin
            do_req(rows[i].op, rows[i].addr, rows[i].data);
            chk_bit(rsp.err, 1'h0);
            if (rows[i].op != sfp_pkg::OP_CMD) chk_byte(rsp.data, rows[i].exp);
        end
        // Burst whose last load strays to another sector
        for (int i = 0; i < 3; i++) begin
            do_req(sfp_pkg::OP_LOAD, (i == 2) ? 17'h1FF82 : 17'h00280 + 17'(i), 8'hC0 + 8'(i));
            chk_bit(rsp.err, 1'h0);
        end
        chk_byte(load_count, 8'h03);
        for (k = 0; k < 200 && prog_busy !== 1'h1; k++) @(posedge mclk) #1;
        chk_bit(prog_busy, 1'h1);
        do_req(sfp_pkg::OP_LOAD, 17'h00290, 8'h11);
        chk_bit(rsp.err, 1'h1);
        do_req(sfp_pkg::OP_POLL, 17'h00000, 8'h00);
        chk_bit(rsp.timeout, 1'h0);
        chk_byte(rsp.data, 8'hC2);
        chk_bit(prog_busy, 1'h0);
        for (int i = 0; i < 3; i++) begin
            do_req(sfp_pkg::OP_READ, 17'h00280 + 17'(i), 8'h00);
            chk_byte(rsp.data, 8'hC0 + 8'(i));
        end
        // Protection on: full sector taken, later bare load dropped; then off and lockout
        do_req(sfp_pkg::OP_CMD, 17'h01555, 8'h11);
        burn(17'h00300, 128);
        chk_bit(sector_full, 1'h1);
        burn(17'h00400, 1);
        chk_bit(sector_full, 1'h0);
        do_req(sfp_pkg::OP_CMD, 17'h01555, 8'h22);
        burn(17'h00380, 128);
        do_req(sfp_pkg::OP_CMD, 17'h01555, 8'h33);
        burn(17'h00000, 1);
        burn(17'h04000, 1);
        for (int i = 0; i < 5; i++) begin
            do_req(sfp_pkg::OP_READ, raddr[i], 8'h00);
            chk_byte(rsp.data, rexp[i]);
        end
        // Second reset in mid-run, while a byte load strobe is low
        req <= '{op: sfp_pkg::OP_LOAD, addr: 17'h04100, data: 8'h77};
        req_valid <= 1'h1;
        @(posedge mclk) #1 req_valid <= 1'h0;
        @(posedge mclk) #1 sys_rst = 1'h1;
        repeat (4) @(posedge mclk);
        #1 sys_rst = 1'h0;
        idle_chk();
        chk_byte(load_count, 8'h00);
        print_verdict();
    end
endmodule // sector_flash_program_control_tb
